// ### hdl/sad_pkg.sv
// shared constants for the stepper axis drive logic
package sad_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 5;
    localparam int FILT_TIME_NS     = 50000;
    // least time, so round up
    localparam int FILT_CYCLES_DFLT =
        (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_CNT_W       = 16;

    // ************************************************************
    // encoder and stepper scaling
    // ************************************************************
    // x4 decoding: one encoder line gives four counts, one step per line
    localparam int QUAD_SHIFT = 2;
    localparam int STAT_CHANS = 3;
    localparam int CH_READY   = 0;
    localparam int CH_INPOS   = 1;
    localparam int CH_FAULT   = 2;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_TARGET    = 8'h08;
    localparam logic [7:0] ADDR_CMD_POS   = 8'h0C;
    localparam logic [7:0] ADDR_ENC_POS   = 8'h10;
    localparam logic [7:0] ADDR_INDEX_POS = 8'h14;
    localparam logic [7:0] ADDR_ERR_LIMIT = 8'h18;
    localparam logic [7:0] ADDR_STEP_HALF = 8'h1C;
    localparam logic [7:0] ADDR_ALM_WIDTH = 8'h20;
    localparam logic [7:0] ADDR_POS_ERR   = 8'h24;

    // control bits
    localparam int CTRL_EN      = 0;
    localparam int CTRL_INPOS   = 1;
    localparam int CTRL_ALM_LVL = 2;
    localparam int CTRL_ALM_GO  = 3;

    // status bits
    localparam int ST_DRV_EN   = 0;
    localparam int ST_DONE     = 1;
    localparam int ST_TRIP     = 2;
    localparam int ST_READY    = 3;
    localparam int ST_INPOS    = 4;
    localparam int ST_FAULT    = 5;
    localparam int ST_IDX      = 6;
    localparam int ST_ALM_BUSY = 7;
    localparam int ST_STEP_BSY = 8;

    // reset values
    localparam logic [31:0] RST_ERR_LIMIT = 32'h0000_1000;
    localparam logic [15:0] RST_STEP_HALF = 16'h0064;
    localparam logic [15:0] RST_ALM_WIDTH = 16'h07D0;

    typedef enum logic [3:0]
    {
        SAD_IDLE = 4'b0001,
        SAD_DIR  = 4'b0010,
        SAD_ACT  = 4'b0100,
        SAD_GAP  = 4'b1000
    } sad_step_e;

endpackage

// ### hdl/sad_filt_if.sv
// raw and filtered level of one status input
`timescale 1ns/1ps
interface sad_filt_if;
    logic raw;
    logic level;

    modport filt
    (
        input  raw,
        output level
    );

    modport user
    (
        output raw,
        input  level
    );
endinterface

// ### hdl/sad_glitch_filter.sv
// synchroniser and glitch filter for one status input
`timescale 1ns/1ps
module sad_glitch_filter
#(
    parameter int FILT_CYCLES = sad_pkg::FILT_CYCLES_DFLT
)
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // filtered line
    sad_filt_if.filt  line
);
    import sad_pkg::*;

    typedef struct packed
    {
        logic [2:0]            sy;
        logic                  level;
        logic [FILT_CNT_W-1:0] cnt;
    } sad_filt_s;

    sad_filt_s s;
    sad_filt_s next_s;

    always_comb
    begin
        next_s    = s;
        next_s.sy = {s.sy[1:0], line.raw};
        // new level must hold for the whole filter time
        if ((s.sy[1] == s.sy[2]) && (s.sy[2] != s.level))
        begin
            if (s.cnt >= FILT_CNT_W'(FILT_CYCLES - 1))
            begin
                next_s.level = s.sy[2];
                next_s.cnt   = '0;
            end
            else
            begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
        else
        begin
            next_s.cnt = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign line.level = s.level;
endmodule

// ### hdl/sad_axis.sv
// stepper axis: encoder, step and direction, supervision, APB registers
//
// What this block does
// R1: encoder edges counted x4, four counts per line.
// R2: encoder A, B and index are active high.
// R3: index accepted only while A and B are both low.
// R4: commands go out as step plus separate direction.
// R5: step and direction are differential; step is active low.
// R6: one step per encoder line, so steps per rev equal resolution.
// R7: position error above limit drops drive enable.
// R8: ready, in-position and fault inputs pass a 50 us filter.
// R9: drive raises ready whenever it is enabled.
// R10: drive raises in-position near its target.
// R11: while fault input is off, no step or direction changes.
// R12: software may pulse alarm clear at drive's width and level.
// R13: software pulses alarm clear only after the cause is gone.
// R14: with in-position criterion on, move done needs in-position.
// R15: drive enable is on when active, off when axis disabled.
// R16: A leading B counts up, B leading A counts down.
// R17: step stays inactive whenever drive enable is low.
`timescale 1ns/1ps
module sad_axis
#(
    parameter int FILT_CYCLES = sad_pkg::FILT_CYCLES_DFLT
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // encoder pins
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_index,
    // drive status pins
    input  wire logic        status_input_one,
    input  wire logic        status_input_two,
    input  wire logic        status_input_three,
    // command pins
    output logic             step_p,
    output logic             step_n,
    output logic             dir_p,
    output logic             dir_n,
    output logic             drive_en,
    output logic             alarm_clr
);
    import sad_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed
    {
        logic [2:0]  a_sy;
        logic [2:0]  b_sy;
        logic [2:0]  z_sy;
        logic        a_q;
        logic        b_q;
        logic        z_q;
        logic [31:0] enc;
        logic [31:0] idx_pos;
        logic [31:0] cmd;
        logic [31:0] target;
        logic [31:0] err_lim;
        logic [15:0] half;
        logic [15:0] alm_w;
        logic [15:0] alm_cnt;
        logic [15:0] step_cnt;
        logic        en;
        logic        inpos_crit;
        logic        alm_lvl;
        logic        alm_on;
        logic        trip;
        logic        idx_seen;
        logic        dir;
        sad_step_e   st;
        logic [31:0] rdata;
    } sad_axis_s;

    sad_axis_s s;
    sad_axis_s next_s;

    // ************************************************************
    // status filters
    // ************************************************************
    logic [STAT_CHANS-1:0] raw_in;
    logic [STAT_CHANS-1:0] filt;

    assign raw_in = {status_input_three, status_input_two,
                     status_input_one};

    for (genvar gi = 0; gi < STAT_CHANS; gi++)
    begin : g_filt
        sad_filt_if fl ();
        assign fl.raw   = raw_in[gi];
        assign filt[gi] = fl.level;
        sad_glitch_filter
        #(.FILT_CYCLES (FILT_CYCLES))
        u_filt
        (
            .clk_sys (clk_sys),
            .sys_rst (sys_rst),
            .line    (fl)
        ); // R8
    end

    logic drv_ready;
    logic drv_inpos;
    logic drv_fault;

    assign drv_ready = filt[CH_READY];
    assign drv_inpos = filt[CH_INPOS];
    // fault line is active when off
    assign drv_fault = ~filt[CH_FAULT]; // R11

    // ************************************************************
    // derived values
    // ************************************************************
    logic [31:0] pos_err;
    logic [31:0] err_abs;
    logic        move_done;
    logic        bus_setup;
    logic        bus_wr;
    logic        addr_ok;
    logic [31:0] status_word;

    // commanded steps scaled to counts
    assign pos_err = (s.cmd << QUAD_SHIFT) - s.enc; // R6
    assign err_abs = pos_err[31] ? (32'h0 - pos_err) : pos_err;
    assign move_done = (s.cmd == s.target) && (s.st == SAD_IDLE)
                       && (!s.inpos_crit || drv_inpos); // R14

    assign bus_setup = psel && !penable;
    assign bus_wr    = psel && penable && pwrite;
    // map is one dense run of aligned words
    assign addr_ok   = (paddr <= ADDR_POS_ERR) && (paddr[1:0] == '0);

    always_comb
    begin
        status_word              = '0;
        status_word[ST_DRV_EN]   = s.en;
        status_word[ST_DONE]     = move_done;
        status_word[ST_TRIP]     = s.trip;
        status_word[ST_READY]    = drv_ready;
        status_word[ST_INPOS]    = drv_inpos;
        status_word[ST_FAULT]    = drv_fault;
        status_word[ST_IDX]      = s.idx_seen;
        status_word[ST_ALM_BUSY] = s.alm_on;
        status_word[ST_STEP_BSY] = (s.st != SAD_IDLE);
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        logic a_acc;
        logic b_acc;
        logic z_acc;
        logic [15:0] half_ld;
        a_acc   = s.a_q;
        b_acc   = s.b_q;
        z_acc   = s.z_q;
        half_ld = (s.half == 16'h0) ? 16'h0 : s.half - 16'h1;
        next_s  = s;

        // read data is latched in setup so access needs no wait
        if (bus_setup && !pwrite)
        begin
            case (paddr)
                ADDR_CTRL:
                    next_s.rdata = {29'h0, s.alm_lvl, s.inpos_crit, s.en};
                ADDR_STATUS:    next_s.rdata = status_word;
                ADDR_TARGET:    next_s.rdata = s.target;
                ADDR_CMD_POS:   next_s.rdata = s.cmd;
                ADDR_ENC_POS:   next_s.rdata = s.enc;
                ADDR_INDEX_POS: next_s.rdata = s.idx_pos;
                ADDR_ERR_LIMIT: next_s.rdata = s.err_lim;
                ADDR_STEP_HALF: next_s.rdata = {16'h0, s.half};
                ADDR_ALM_WIDTH: next_s.rdata = {16'h0, s.alm_w};
                ADDR_POS_ERR:   next_s.rdata = pos_err;
                default:        next_s.rdata = '0;
            endcase
        end

        // countdown ahead of the bus write, so a fresh start wins
        if (s.alm_on)
        begin
            if (s.alm_cnt == 16'h0)
                next_s.alm_on = 1'b0;
            else
                next_s.alm_cnt = s.alm_cnt - 16'h1;
        end

        // bus writes first so hardware events below win
        if (bus_wr)
        begin
            case (paddr)
                ADDR_CTRL:
                begin
                    next_s.en         = pwdata[CTRL_EN];
                    next_s.inpos_crit = pwdata[CTRL_INPOS];
                    next_s.alm_lvl    = pwdata[CTRL_ALM_LVL];
                    if (pwdata[CTRL_EN])
                        next_s.trip = 1'b0;
                    if (pwdata[CTRL_ALM_GO])
                    begin
                        next_s.alm_on  = 1'b1; // R12
                        next_s.alm_cnt = s.alm_w;
                    end
                end
                ADDR_STATUS:
                    if (pwdata[ST_IDX])
                        next_s.idx_seen = 1'b0;
                ADDR_TARGET:    next_s.target  = pwdata;
                ADDR_ERR_LIMIT: next_s.err_lim = pwdata;
                ADDR_STEP_HALF: next_s.half    = pwdata[15:0];
                ADDR_ALM_WIDTH: next_s.alm_w   = pwdata[15:0];
                default:        next_s.en      = next_s.en;
            endcase
        end

        // encoder pins: accept a level once the 2nd and 3rd flops agree
        next_s.a_sy = {s.a_sy[1:0], enc_a};
        next_s.b_sy = {s.b_sy[1:0], enc_b};
        next_s.z_sy = {s.z_sy[1:0], enc_index};
        if (s.a_sy[1] == s.a_sy[2])
            a_acc = s.a_sy[2]; // R2
        if (s.b_sy[1] == s.b_sy[2])
            b_acc = s.b_sy[2];
        if (s.z_sy[1] == s.z_sy[2])
            z_acc = s.z_sy[2];
        next_s.a_q = a_acc;
        next_s.b_q = b_acc;
        next_s.z_q = z_acc;

        // every legal edge counts; a double change is a lost state
        if ((a_acc ^ s.a_q) ^ (b_acc ^ s.b_q)) // R1
        begin
            if (a_acc ^ s.b_q)
                next_s.enc = s.enc + 32'h1; // R16
            else
                next_s.enc = s.enc - 32'h1; // R16
        end

        if (z_acc && !s.z_q && !a_acc && !b_acc) // R3
        begin
            next_s.idx_pos  = next_s.enc;
            next_s.idx_seen = 1'b1;
        end

        // step generator
        case (s.st)
            SAD_IDLE:
                if (s.en && !drv_fault && (s.cmd != s.target))
                begin
                    next_s.dir      = $signed(s.target) > $signed(s.cmd);
                    next_s.step_cnt = half_ld;
                    next_s.st       = SAD_DIR; // R4
                end
            SAD_DIR:
                if (s.step_cnt == 16'h0)
                begin
                    next_s.cmd      = s.dir ? s.cmd + 32'h1 : s.cmd - 32'h1;
                    next_s.step_cnt = half_ld;
                    next_s.st       = SAD_ACT;
                end
                else
                    next_s.step_cnt = s.step_cnt - 16'h1;
            SAD_ACT:
                if (s.step_cnt == 16'h0)
                begin
                    next_s.step_cnt = half_ld;
                    next_s.st       = SAD_GAP;
                end
                else
                    next_s.step_cnt = s.step_cnt - 16'h1;
            SAD_GAP:
                if (s.step_cnt == 16'h0)
                    next_s.st = SAD_IDLE;
                else
                    next_s.step_cnt = s.step_cnt - 16'h1;
            default:
                next_s.st = SAD_IDLE;
        endcase
        // a fault or a disable ends the step at once
        if (drv_fault || !s.en) // R11 R17
            next_s.st = SAD_IDLE;

        // position error supervision
        if (s.en && (err_abs > s.err_lim))
        begin
            next_s.en   = 1'b0; // R7
            next_s.trip = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s         <= '0;
            s.st      <= SAD_IDLE;
            s.err_lim <= RST_ERR_LIMIT;
            s.half    <= RST_STEP_HALF;
            s.alm_w   <= RST_ALM_WIDTH;
        end
        else
            s <= next_s;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic step_on;

    assign step_on  = (s.st == SAD_ACT) && s.en; // R17
    assign step_p   = ~step_on; // R5
    assign step_n   = step_on;
    assign dir_p    = s.dir; // R5
    assign dir_n    = ~s.dir;
    // high turns the sinking output on
    assign drive_en = s.en; // R15
    assign alarm_clr = s.alm_on ? s.alm_lvl : ~s.alm_lvl;

    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_ok;
    assign prdata   = s.rdata;
endmodule

// ### tb/sad_axis_asserts.sv
// port checker for the stepper axis
`timescale 1ns/1ps
module sad_axis_asserts
    import sad_pkg::*;
#(
    parameter int FILT_CYCLES = 8
)
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // pins
    input wire logic        status_input_three,
    input wire logic        step_p,
    input wire logic        step_n,
    input wire logic        dir_p,
    input wire logic        dir_n,
    input wire logic        drive_en,
    input wire logic        alarm_clr
);
    // ********
    // helpers
    // ********
    logic [15:0] flt_cnt;
    logic        wr_ctrl;
    logic        en_wr;
    assign wr_ctrl = psel && penable && pwrite && paddr == ADDR_CTRL;
    assign en_wr   = wr_ctrl && pwdata[CTRL_EN];
    // sync plus filter plus one edge to force idle, with margin
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || status_input_three)
            flt_cnt <= 16'h0;
        else if (flt_cnt != 16'hFFFF)
            flt_cnt <= flt_cnt + 16'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ********
    // properties
    // ********
    property p_step_pair;
        step_n == !step_p;
    endproperty
    a_step_pair: assert property (p_step_pair)
        else $error("step pair not complementary");
    property p_dir_pair;
        dir_n == !dir_p;
    endproperty
    a_dir_pair: assert property (p_dir_pair)
        else $error("direction pair not complementary");
    property p_step_off;
        !drive_en && !$past(drive_en) |-> step_p;
    endproperty
    a_step_off: assert property (p_step_off)
        else $error("step active while drive disabled");
    property p_dir_hold;
        !step_p |-> $stable(dir_p);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction moved during step pulse");
    property p_fault_step;
        flt_cnt > FILT_CYCLES + 8 |-> step_p;
    endproperty
    a_fault_step: assert property (p_fault_step)
        else $error("step pulse during fault");
    property p_fault_dir;
        flt_cnt > FILT_CYCLES + 8 |-> $stable(dir_p);
    endproperty
    a_fault_dir: assert property (p_fault_dir)
        else $error("direction change during fault");
    property p_en_rise;
        $rose(drive_en) |-> $past(en_wr);
    endproperty
    a_en_rise: assert property (p_en_rise)
        else $error("drive enable rose without enable write");
    property p_alarm_go;
        wr_ctrl && pwdata[CTRL_ALM_GO] |=>
            alarm_clr == $past(pwdata[CTRL_ALM_LVL]);
    endproperty
    a_alarm_go: assert property (p_alarm_go)
        else $error("alarm pulse not at chosen level");
endmodule

// ### tb/sad_drive_model.sv
// behavioural servo drive with encoder feedback
`timescale 1ns/1ps
module sad_drive_model
(
    // clock and command pins
    input  wire logic clk_sys,
    input  wire logic step_p,
    input  wire logic dir_p,
    input  wire logic drive_en,
    // test controls
    input  wire logic slip,
    input  wire logic hold_inpos,
    // feedback pins
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_index,
    output logic      ready,
    output logic      inpos
);
    int   pos    = 0;
    int   tgt    = 0;
    int   tick   = 0;
    logic step_q = 1'b1;
    // one line per step; slip moves the shaft with no command
    always @(posedge clk_sys)
    begin
        step_q <= step_p;
        if (step_q && !step_p)
            tgt <= tgt + (dir_p ? 4 : -4);
        else if (slip)
            tgt <= tgt + 4;
        tick <= (tick + 1) % 4;
        if (tick == 0 && pos != tgt)
            pos <= pos + ((tgt > pos) ? 1 : -1);
    end
    assign enc_a     = pos[0] ^ pos[1];
    assign enc_b     = pos[1];
    assign enc_index = (pos == 4);
    assign ready     = drive_en;
    assign inpos     = (pos == tgt) && !hold_inpos;
endmodule

// ### tb/tb.sv
// self-checking bench for the stepper axis
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
    fails++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb;
    import sad_pkg::*;
    localparam int FC = 8;
    typedef struct {logic [31:0] exp; logic [31:0] msk; logic err;} sad_note_s;
    logic        clk_sys, sys_rst, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, seed;
    logic        pready, pslverr, enc_a, enc_b, enc_index;
    logic        status_input_one, status_input_two, status_input_three;
    logic        step_p, step_n, dir_p, dir_n, drive_en, alarm_clr;
    logic        slip, hold_inpos;
    logic [32:0] got;
    int          fails, checks_done, cur, t, n;
    sad_note_s   notes[$];
    sad_note_s   nt;

    sad_axis #(.FILT_CYCLES(FC)) uut (.clk_sys, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enc_a,
        .enc_b, .enc_index, .status_input_one, .status_input_two,
        .status_input_three, .step_p, .step_n, .dir_p, .dir_n, .drive_en,
        .alarm_clr);
    sad_drive_model drv (.clk_sys, .step_p, .dir_p, .drive_en, .slip,
        .hold_inpos, .enc_a, .enc_b, .enc_index,
        .ready(status_input_one), .inpos(status_input_two));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ********
    // apb master
    // ********
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
        begin
            fails++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        notes.push_back('{e, m, a > ADDR_POS_ERR});
        apb(1'b0, a, 32'h0, q);
    endtask
    task automatic poll(input int b, input logic v);
        int k;
        k = 0;
        do
        begin
            rd(ADDR_STATUS, 32'h0, 32'h0);
            k++;
        end
        while (q[b] !== v && k < 300);
        if (k >= 300)
        begin
            fails++;
            final_report();
        end
    endtask
    task automatic move(input int tg);
        wr(ADDR_TARGET, 32'(tg));
        poll(ST_DONE, 1'b1);
        rd(ADDR_CMD_POS, 32'(tg), '1);
        rd(ADDR_ENC_POS, 32'(tg * 4), '1);
        rd(ADDR_POS_ERR, 32'h0, '1);
        `CHK("dir_p", (tg > cur), dir_p)
        cur = tg;
    endtask

    // read results are judged here, oldest note first
    always @(posedge clk_sys)
    begin
        if (psel && penable && pready && !pwrite && notes.size() > 0)
        begin
            nt  = notes.pop_front();
            got = {pslverr, prdata & nt.msk};
            if (nt.msk != 32'h0)
                `CHK("prdata", {nt.err, nt.exp & nt.msk}, got)
        end
    end

    initial
    begin
        seed = 32'h2AC24E2F;
        {sys_rst, psel, penable, pwrite, slip, hold_inpos} = 6'b100000;
        paddr = 8'h00;
        pwdata = 32'h0;
        status_input_three = 1'b1;
        fails = 0;
        checks_done = 0;
        cur = 0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(ADDR_ERR_LIMIT, RST_ERR_LIMIT, '1);
        rd(ADDR_STEP_HALF, {16'h0, RST_STEP_HALF}, '1);
        rd(ADDR_ALM_WIDTH, {16'h0, RST_ALM_WIDTH}, '1);
        rd(8'h28, 32'h0, '1);
        wr(ADDR_CMD_POS, 32'h5);
        rd(ADDR_CMD_POS, 32'h0, '1);
        // long half periods keep the in-position filter ahead of done
        wr(ADDR_STEP_HALF, 32'h8 + ($random(seed) & 32'h7));
        wr(ADDR_CTRL, 32'h3);
        poll(ST_READY, 1'b1);
        rd(ADDR_STATUS, 32'h9, 32'h2D);
        move(2);
        rd(ADDR_STATUS, 32'h40, 32'h40);
        rd(ADDR_INDEX_POS, 32'h4, '1);
        wr(ADDR_STATUS, 32'h40);
        rd(ADDR_STATUS, 32'h0, 32'h40);
        for (int i = 0; i < 3; i++)
        begin
            t = $random(seed) % 4;
            move((t == cur) ? cur - 1 : t);
        end
        hold_inpos <= 1'b1;
        wr(ADDR_TARGET, 32'(cur + 1));
        poll(ST_STEP_BSY, 1'b0);
        rd(ADDR_STATUS, 32'h0, 32'h2);
        wr(ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL, 32'h1, '1);
        rd(ADDR_STATUS, 32'h2, 32'h2);
        wr(ADDR_CTRL, 32'h3);
        hold_inpos <= 1'b0;
        poll(ST_DONE, 1'b1);
        cur = cur + 1;
        status_input_three <= 1'b0;
        repeat (3) @(posedge clk_sys);
        status_input_three <= 1'b1;
        rd(ADDR_STATUS, 32'h0, 32'h20);
        status_input_three <= 1'b0;
        repeat (FC + 8) @(posedge clk_sys);
        rd(ADDR_STATUS, 32'h20, 32'h20);
        wr(ADDR_TARGET, 32'(cur + 2));
        repeat (60) @(posedge clk_sys);
        rd(ADDR_CMD_POS, 32'(cur), '1);
        status_input_three <= 1'b1;
        move(cur + 2);
        wr(ADDR_ERR_LIMIT, 32'h8);
        slip <= 1'b1;
        repeat (2) @(posedge clk_sys);
        slip <= 1'b0;
        repeat (50) @(posedge clk_sys);
        rd(ADDR_POS_ERR, 32'hFFFF_FFF8, '1);
        rd(ADDR_STATUS, 32'h1, 32'h5);
        slip <= 1'b1;
        @(posedge clk_sys);
        slip <= 1'b0;
        poll(ST_TRIP, 1'b1);
        `CHK("drive_en", 1'b0, drive_en)
        // cause cleared first: fault line is high again
        wr(ADDR_ALM_WIDTH, 32'h5);
        wr(ADDR_CTRL, 32'hC);
        n = 0;
        for (int k = 0; k < 20; k++)
        begin
            @(posedge clk_sys);
            n += (alarm_clr === 1'b1);
        end
        `CHK("alarm width", 6, n)
        final_report();
    end
endmodule
bind sad_axis sad_axis_asserts #(.FILT_CYCLES(FILT_CYCLES)) u_chk (.*);
